// ===== iar_map.svh
/*
 Offsets, field positions and timing figures of the acknowledgement and
 retransmission block. Definitions only; included by every design file but the type package.
*/
`ifndef IAR_MAP_SVH
`define IAR_MAP_SVH

// Regular acknowledgement bits
`define IAR_B_UTC 20
`define IAR_B_ACK 21
`define IAR_ACK_W 37

// Extension data bits
`define IAR_EXT_W 8
`define IAR_E_TYPE 0
`define IAR_E_UTCE 1

// Partial recommendation, MS-MPDU wide bandplans
`define IAR_FM_RSCW 30
`define IAR_FM_CCR 31
`define IAR_FM_REP 32
`define IAR_FM_INTM 34
`define IAR_FM_MOD 35

// Partial recommendation, MS-MPDU narrow bandplans
`define IAR_CM_RSCW 22
`define IAR_CM_CCR 23
`define IAR_CM_REP 24
`define IAR_CM_INTM 26
`define IAR_CM_MOD 27

// Partial recommendation, SS-MPDU
`define IAR_SS_RSCW 22
`define IAR_SS_REP 23
`define IAR_SS_INTM 25

// Codes
`define IAR_TP_REQ_PART 2'h3
`define IAR_REP_NOCHG 2'h0

// Timing
`define IAR_CLK_MHZ 200
`define IAR_MAX_ACK_RX_US 1000
`define IAR_ACK_WAIT_US 10
`define IAR_MAX_RETX 3

`endif

// ===== iar_pkg.sv
/*
 Types of the acknowledgement and retransmission block.
 Assumes nothing of its surroundings.
*/
package iar_pkg;
  typedef enum logic [2:0] {
    IAR_IDLE = 3'b000,
    IAR_SEND = 3'b001,
    IAR_WDONE = 3'b010,
    IAR_WACK = 3'b011,
    IAR_P3SEND = 3'b100,
    IAR_P3WAIT = 3'b101
  } iar_state_e;
endpackage

// ===== iar_ack_build.sv
/*
 Builds the regular and extension acknowledgement words of an outgoing
 Imm-ACK. Assumes build requests and field values come from logic on mclk_i.
*/
`include "iar_map.svh"
`timescale 1ns/1ps
`default_nettype none
module iar_ack_build
  import iar_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Request
  input wire logic build_i,
  input wire logic [5:0] src_id_i,
  input wire logic wide_band_i,
  input wire logic ss_mpdu_i,
  input wire logic utc_i,
  input wire logic rx_ok_i,
  input wire logic [1:0] tp_req_i,
  input wire logic est_ok_i,
  input wire logic ext_utce_i,
  // Recommended and assigned values
  input wire logic [5:0] rec_i,
  input wire logic [5:0] asg_i,
  // Result
  output logic [`IAR_ACK_W-1:0] ack_o,
  output logic [`IAR_EXT_W-1:0] ext_o
);
  logic pend_q;
  logic [5:0] pend_src_q;
  logic req_part;
  logic late_ok;
  logic fill;
  logic [5:0] v;
  logic [1:0] rep;
  logic [1:0] mod;
  logic [`IAR_ACK_W-1:0] ack_d;
  logic [`IAR_EXT_W-1:0] ext_d;

  // R4 R5 partial report, now or deferred
  assign req_part = (tp_req_i == `IAR_TP_REQ_PART);
  assign late_ok = pend_q && (pend_src_q == src_id_i);
  assign fill = (req_part || late_ok) && est_ok_i;
  // R6 R13 no change echoes assigned values
  assign v = fill ? rec_i : asg_i;
  assign rep = fill ? rec_i[3:2] : `IAR_REP_NOCHG;
  // R12 R13 modulation pair is bits 4 and 5 of the value vectors
  assign mod = fill ? {rec_i[4], rec_i[5]} : {asg_i[4], asg_i[5]};

  always_comb begin
    // R3 reserved bits zero
    ack_d = '0;
    // R23 R24 regular status bits
    ack_d[`IAR_B_UTC] = utc_i;
    ack_d[`IAR_B_ACK] = rx_ok_i & ~utc_i;
    if (ss_mpdu_i) begin
      // R8 R10 R11 short layout
      ack_d[`IAR_SS_RSCW] = v[0];
      ack_d[`IAR_SS_REP+:2] = rep;
      ack_d[`IAR_SS_INTM] = v[1];
    end else if (wide_band_i) begin
      // R8 R9 R10 R11 R12 wide layout
      ack_d[`IAR_FM_RSCW] = v[0];
      ack_d[`IAR_FM_CCR] = v[5];
      ack_d[`IAR_FM_REP+:2] = rep;
      ack_d[`IAR_FM_INTM] = v[1];
      ack_d[`IAR_FM_MOD+:2] = mod;
    end else begin
      ack_d[`IAR_CM_RSCW] = v[0];
      ack_d[`IAR_CM_CCR] = v[5];
      ack_d[`IAR_CM_REP+:2] = rep;
      ack_d[`IAR_CM_INTM] = v[1];
      ack_d[`IAR_CM_MOD+:2] = mod;
    end
    ext_d = '0;
    // R1 type bit
    ext_d[`IAR_E_TYPE] = ss_mpdu_i;
    // R2 unable-to-comply bit
    ext_d[`IAR_E_UTCE] = ext_utce_i;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= '0;
      ext_o <= '0;
      pend_q <= 1'b0;
      pend_src_q <= 6'h00;
    end else if (build_i) begin
      ack_o <= ack_d;
      ext_o <= ext_d;
      // R5 remember a late report
      if (req_part && !est_ok_i) begin
        pend_q <= 1'b1;
        pend_src_q <= src_id_i;
      end else if (late_ok && est_ok_i) begin
        pend_q <= 1'b0;
      end
    end
  end
endmodule // iar_ack_build
`default_nettype wire

// ===== iar_ack_parse.sv
/*
 Decodes a received Imm-ACK for the transmit controller.
 Assumes the word arrives from logic on the same clock.
*/
`include "iar_map.svh"
`timescale 1ns/1ps
`default_nettype none
module iar_ack_parse (
  // Received words
  input wire logic [`IAR_ACK_W-1:0] ack_i,
  input wire logic [`IAR_EXT_W-1:0] ext_i,
  // Decoded status
  output logic utc_o,
  output logic ok_o,
  output logic ss_type_o
);
  // R3 reserved bits ignored; R23 R24 status decode
  assign utc_o = ack_i[`IAR_B_UTC];
  assign ok_o = ack_i[`IAR_B_ACK] & ~ack_i[`IAR_B_UTC];
  // R1 type bit
  assign ss_type_o = ext_i[`IAR_E_TYPE];
endmodule // iar_ack_parse
`default_nettype wire

// ===== iar_retx_ctrl.sv
/*
 Transmit-side retransmission controller of the acknowledgement block,
 with the outgoing acknowledgement builder and incoming decoder.
 Assumes the MAC, upper layer and receive path run on mclk_i.
*/
`include "iar_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Extension bit 0 gives acknowledgement type, 0 MS-MPDU, 1 SS-MPDU.
// R2: Extension bit 1 set when requested extension content cannot be given.
// R3: Reserved bits sent as zero and ignored on receipt.
// R4: Partial recommendation filled when transmitter requested it with code 11.
// R5: Late recommendation sends No change now, report in next ack from source.
// R6: Without request, every recommendation field carries No change.
// R7: Narrow bandplans forbid selective ack with partial request; far side's duty.
// R8: Codeword size bit at 30, or 22 for narrow MS and all SS.
// R9: Code rate bit at 31 or 23; absent for SS-MPDU.
// R10: Repetition field 33:32, 25:24 or 24:23; 00 no change.
// R11: Interleaving bit at 34, 26 or 25 by layout.
// R12: Modulation field 36:35 or 28:27; absent for SS-MPDU.
// R13: Non-repetition fields echo assigned value when no estimate exists.
// R14: Multicast and broadcast frames never request acknowledgement.
// R15: Every MPDU of an acknowledged frame requests acknowledgement.
// R16: Errored unit is resent before others; only priority 3 passes.
// R17: No new frame until earlier frames cleared or timed out.
// R18: Priority 3 MPDU sent at once, interrupting frame in progress; code holds it while in IAR_WACK.
// R19: Receiver unable to take MS-MPDU: resend in SS-MPDU mode.
// R20: After maximum retransmissions, discard frame and report failure.
// R21: Same failure report when frame window timer expires.
// R22: Frame window timer frozen while a priority 3 frame interrupts.
// R23: Regular ack bit 20 marks receiver unable to process MS-MPDU.
// R24: Regular ack bit 21 is 1 for error-free, 0 for errored.
// R25: Failure shown as one-cycle pulse with discarded frame identifier.
module iar_retx_ctrl
  import iar_pkg::*;
#(
  parameter int MAX_RETX = `IAR_MAX_RETX,
  parameter int MAX_ACK_RX_CYC = `IAR_MAX_ACK_RX_US * `IAR_CLK_MHZ,
  parameter int ACK_WAIT_CYC = `IAR_ACK_WAIT_US * `IAR_CLK_MHZ
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Upper layer frame request
  input wire logic frm_req_i,
  input wire logic [7:0] frm_id_i,
  input wire logic [7:0] frm_nmpdu_i,
  input wire logic frm_ack_i,
  input wire logic frm_mcast_i,
  input wire logic frm_ss_i,
  output logic frm_ready_o,
  output logic frm_done_o,
  output logic frm_fail_o,
  output logic [7:0] frm_id_o,
  // Priority 3 traffic
  input wire logic p3_req_i,
  input wire logic p3_rx_busy_i,
  // MAC transmit command
  output logic mpdu_send_o,
  output logic [7:0] mpdu_idx_o,
  output logic mpdu_ackreq_o,
  output logic mpdu_ss_o,
  output logic mpdu_p3_o,
  output logic mpdu_abort_o,
  input wire logic mpdu_done_i,
  // Received acknowledgement
  input wire logic rack_valid_i,
  input wire logic [`IAR_ACK_W-1:0] rack_i,
  input wire logic [`IAR_EXT_W-1:0] rext_i,
  // Outgoing acknowledgement request
  input wire logic tack_build_i,
  input wire logic [5:0] tack_src_i,
  input wire logic tack_wide_i,
  input wire logic tack_ss_i,
  input wire logic tack_utc_i,
  input wire logic tack_ok_i,
  input wire logic [1:0] tack_tp_req_i,
  input wire logic tack_est_ok_i,
  input wire logic tack_utce_i,
  input wire logic [5:0] tack_rec_i,
  input wire logic [5:0] tack_asg_i,
  output logic [`IAR_ACK_W-1:0] tack_o,
  output logic [`IAR_EXT_W-1:0] text_o
);
  iar_state_e state_q, state_d;
  iar_state_e ret_q, ret_d;
  logic [7:0] id_q, id_d;
  logic [7:0] n_q, n_d;
  logic [7:0] idx_q, idx_d;
  logic ackreq_q, ackreq_d;
  logic ss_q, ss_d;
  logic [7:0] retx_q, retx_d;
  logic [31:0] win_q, win_d;
  logic [31:0] wait_q, wait_d;
  logic send_d, p3_d, abort_d, done_d, fail_d, ready_d;
  logic rx_utc, rx_ok;
  logic win_exp, wait_exp, freeze, active, last, retry_out;

  iar_ack_build u_build (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .build_i(tack_build_i),
    .src_id_i(tack_src_i),
    .wide_band_i(tack_wide_i),
    .ss_mpdu_i(tack_ss_i),
    .utc_i(tack_utc_i),
    .rx_ok_i(tack_ok_i),
    .tp_req_i(tack_tp_req_i),
    .est_ok_i(tack_est_ok_i),
    .ext_utce_i(tack_utce_i),
    .rec_i(tack_rec_i),
    .asg_i(tack_asg_i),
    .ack_o(tack_o),
    .ext_o(text_o)
  );

  iar_ack_parse u_parse (
    .ack_i(rack_i),
    .ext_i(rext_i),
    .utc_o(rx_utc),
    .ok_o(rx_ok),
    .ss_type_o()
  );

  assign active = (state_q != IAR_IDLE) && (ret_q != IAR_IDLE || state_q < IAR_P3SEND);
  // R22 timer frozen during priority 3 exchange
  assign freeze = p3_rx_busy_i || state_q == IAR_P3SEND || state_q == IAR_P3WAIT;
  // R21 frame window expiry
  assign win_exp = active && !freeze && (win_q == 32'(MAX_ACK_RX_CYC - 1));
  assign wait_exp = (wait_q == 32'(ACK_WAIT_CYC - 1));
  assign last = (idx_q + 8'h01 >= n_q);
  // R20 retransmission limit
  assign retry_out = (retx_q >= 8'(MAX_RETX));

  always_comb begin
    state_d = state_q;
    ret_d = ret_q;
    id_d = id_q;
    n_d = n_q;
    idx_d = idx_q;
    ackreq_d = ackreq_q;
    ss_d = ss_q;
    retx_d = retx_q;
    win_d = (active && !freeze) ? win_q + 32'h1 : win_q;
    wait_d = 32'h0;
    send_d = 1'b0;
    p3_d = 1'b0;
    abort_d = 1'b0;
    done_d = 1'b0;
    fail_d = 1'b0;
    case (state_q)
      IAR_IDLE: begin
        if (p3_req_i) begin
          ret_d = IAR_IDLE;
          state_d = IAR_P3SEND;
        // R17 new frame only when idle
        end else if (frm_req_i) begin
          id_d = frm_id_i;
          n_d = (frm_nmpdu_i == 8'h00) ? 8'h01 : frm_nmpdu_i;
          idx_d = 8'h00;
          // R14 no ack for group frames
          ackreq_d = frm_ack_i && !frm_mcast_i;
          ss_d = frm_ss_i;
          retx_d = 8'h00;
          win_d = 32'h0;
          state_d = IAR_SEND;
        end
      end
      IAR_SEND: begin
        // R18 priority 3 goes first
        if (p3_req_i) begin
          ret_d = IAR_SEND;
          state_d = IAR_P3SEND;
        end else begin
          // R15 every MPDU carries the frame's ack request
          send_d = 1'b1;
          state_d = IAR_WDONE;
        end
      end
      IAR_WDONE: begin
        if (p3_req_i) begin
          // R18 interrupt the frame in progress
          abort_d = 1'b1;
          ret_d = IAR_SEND;
          state_d = IAR_P3SEND;
        end else if (mpdu_done_i) begin
          if (ackreq_q) begin
            state_d = IAR_WACK;
          end else if (last) begin
            done_d = 1'b1;
            state_d = IAR_IDLE;
          end else begin
            idx_d = idx_q + 8'h01;
            state_d = IAR_SEND;
          end
        end
      end
      IAR_WACK: begin
        wait_d = wait_q + 32'h1;
        if (rack_valid_i && rx_ok) begin
          retx_d = 8'h00;
          if (last) begin
            done_d = 1'b1;
            state_d = IAR_IDLE;
          end else begin
            idx_d = idx_q + 8'h01;
            state_d = IAR_SEND;
          end
        end else if (rack_valid_i || wait_exp) begin
          // R19 fall back to single-segment mode
          if (rack_valid_i && rx_utc) begin
            ss_d = 1'b1;
          end
          // R16 resend the errored unit before anything else
          if (retry_out) begin
            fail_d = 1'b1;
            state_d = IAR_IDLE;
          end else begin
            retx_d = retx_q + 8'h01;
            state_d = IAR_SEND;
          end
        end
      end
      IAR_P3SEND: begin
        send_d = 1'b1;
        p3_d = 1'b1;
        state_d = IAR_P3WAIT;
      end
      IAR_P3WAIT: begin
        if (mpdu_done_i) begin
          state_d = ret_q;
        end
      end
      default: begin
        state_d = IAR_IDLE;
      end
    endcase
    // R21 R25 window expiry discards the frame
    if (win_exp && state_d != IAR_IDLE && !done_d && !fail_d) begin
      fail_d = 1'b1;
      abort_d = (state_q == IAR_WDONE);
      state_d = IAR_IDLE;
    end
    if (state_d == IAR_IDLE) begin
      win_d = 32'h0;
      ret_d = IAR_IDLE;
    end
    ready_d = (state_d == IAR_IDLE) && !p3_req_i;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= IAR_IDLE;
      ret_q <= IAR_IDLE;
      id_q <= 8'h00;
      n_q <= 8'h00;
      idx_q <= 8'h00;
      ackreq_q <= 1'b0;
      ss_q <= 1'b0;
      retx_q <= 8'h00;
      win_q <= 32'h0;
      wait_q <= 32'h0;
    end else begin
      state_q <= state_d;
      ret_q <= ret_d;
      id_q <= id_d;
      n_q <= n_d;
      idx_q <= idx_d;
      ackreq_q <= ackreq_d;
      ss_q <= ss_d;
      retx_q <= retx_d;
      win_q <= win_d;
      wait_q <= wait_d;
    end
  end

  // Output flops
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mpdu_send_o <= 1'b0;
      mpdu_idx_o <= 8'h00;
      mpdu_ackreq_o <= 1'b0;
      mpdu_ss_o <= 1'b0;
      mpdu_p3_o <= 1'b0;
      mpdu_abort_o <= 1'b0;
      frm_done_o <= 1'b0;
      frm_fail_o <= 1'b0;
      frm_id_o <= 8'h00;
      frm_ready_o <= 1'b0;
    end else begin
      mpdu_send_o <= send_d;
      mpdu_idx_o <= idx_q;
      mpdu_ackreq_o <= ackreq_q && !p3_d;
      mpdu_ss_o <= ss_q;
      mpdu_p3_o <= p3_d;
      mpdu_abort_o <= abort_d;
      frm_done_o <= done_d;
      // R25 single-cycle failure with frame identifier
      frm_fail_o <= fail_d;
      frm_id_o <= id_q;
      frm_ready_o <= ready_d;
    end
  end
endmodule // iar_retx_ctrl
`default_nettype wire

// ===== iar_chk.sv
/* Port checker of the retransmission controller.
   Assumes a bench that holds frame inputs steady for the whole frame. */
`timescale 1ns/1ps
`default_nettype none
module iar_chk (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Frame port
  input wire logic frm_req_i,
  input wire logic [7:0] frm_id_i,
  input wire logic frm_ack_i,
  input wire logic frm_mcast_i,
  input wire logic frm_ready_o,
  input wire logic frm_done_o,
  input wire logic frm_fail_o,
  input wire logic [7:0] frm_id_o,
  input wire logic p3_req_i,
  // MAC port
  input wire logic mpdu_send_o,
  input wire logic [7:0] mpdu_idx_o,
  input wire logic mpdu_ackreq_o,
  input wire logic mpdu_ss_o,
  input wire logic mpdu_p3_o,
  input wire logic mpdu_abort_o,
  input wire logic rack_valid_i,
  input wire logic [36:0] rack_i,
  // Ack builder
  input wire logic tack_build_i,
  input wire logic tack_wide_i,
  input wire logic tack_ss_i,
  input wire logic tack_utc_i,
  input wire logic tack_ok_i,
  input wire logic [1:0] tack_tp_req_i,
  input wire logic tack_est_ok_i,
  input wire logic tack_utce_i,
  input wire logic [5:0] tack_asg_i,
  input wire logic [36:0] tack_o,
  input wire logic [7:0] text_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_take;
    frm_req_i && frm_ready_o && !p3_req_i;
  endsequence
  sequence s_first;
    ##2 mpdu_send_o && mpdu_idx_o == 8'h00 && frm_id_o == $past(frm_id_i, 2);
  endsequence
  a_take_send: assert property (s_take |-> s_first)
    else $error("first send missing after frame taken");
  a_busy_noready: assert property (mpdu_send_o |-> !frm_ready_o)
    else $error("ready while sending");
  a_mcast_noreq: assert property (mpdu_send_o && frm_mcast_i && !mpdu_p3_o |-> !mpdu_ackreq_o)
    else $error("ack requested for multicast");
  a_ackreq_each: assert property (
    mpdu_send_o && frm_ack_i && !frm_mcast_i && !mpdu_p3_o |-> mpdu_ackreq_o)
    else $error("ack request missing");
  a_nack_retry: assert property (
    rack_valid_i && !rack_i[20] && !rack_i[21] |-> ##[1:3] (mpdu_send_o || frm_fail_o))
    else $error("no retransmit after nack");
  a_unable_ss: assert property (
    rack_valid_i && rack_i[20] |-> ##[1:3] (mpdu_send_o && mpdu_ss_o || frm_fail_o))
    else $error("no single segment resend");
  a_fail_pulse: assert property (frm_fail_o |=> !frm_fail_o && !frm_done_o && $stable(frm_id_o))
    else $error("fail not a single pulse");
  a_ext_fields: assert property (
    tack_build_i |=> text_o == {6'h00, $past(tack_utce_i), $past(tack_ss_i)})
    else $error("extension word wrong");
  a_reg_bits: assert property (
    tack_build_i |=> tack_o[21:0] == {$past(tack_ok_i), $past(tack_utc_i), 20'h00000})
    else $error("regular ack bits wrong");
  a_no_request: assert property (
    tack_build_i && tack_tp_req_i != 2'h3 && !tack_est_ok_i && tack_wide_i && !tack_ss_i
    |=> tack_o[33:30] == {2'h0, $past(tack_asg_i[5]), $past(tack_asg_i[0])})
    else $error("no change fields wrong");
  c_abort: cover property (mpdu_abort_o);
endmodule // iar_chk
bind iar_retx_ctrl iar_chk u_chk (.*);
`default_nettype wire

// ===== iar_node_model.sv
/* MAC and remote node model: finishes each MPDU lat_i + 1 cycles after taking the send and
   answers with ack, nack, unable or silence. Assumes one send at a time. */
`timescale 1ns/1ps
`default_nettype none
module iar_node_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Commands
  input wire logic send_i,
  input wire logic abort_i,
  input wire logic [1:0] mode_i,
  input wire logic [3:0] lat_i,
  // Answers
  output logic done_o,
  output logic ack_v_o,
  output logic [36:0] ack_o,
  output logic [7:0] ext_o
);
  logic [3:0] cnt_q;
  logic [1:0] ph_q;
  logic tog_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 4'h0;
      ph_q <= 2'h0;
      done_o <= 1'b0;
      ack_v_o <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      done_o <= 1'b0;
      ack_v_o <= 1'b0;
      tog_q <= ~tog_q;
      cnt_q <= cnt_q - 4'h1;
      if (send_i) begin
        ph_q <= 2'h1;
        cnt_q <= lat_i;
      end else if (abort_i) begin
        ph_q <= 2'h0;
      end else if (ph_q == 2'h1 && cnt_q == 4'h0) begin
        done_o <= 1'b1;
        ph_q <= 2'h2;
        cnt_q <= 4'h2;
      end else if (ph_q == 2'h2 && cnt_q == 4'h0) begin
        ack_v_o <= mode_i != 2'h3;
        ph_q <= 2'h0;
      end
    end
  end
  assign ack_o = ack_v_o ? {15'h0, mode_i == 2'h0, mode_i == 2'h2, 20'h0} : {37{tog_q}};
  assign ext_o = ack_v_o ? 8'h00 : {8{tog_q}};
endmodule // iar_node_model
`default_nettype wire

// ===== imm_ack_retransmit_control_tb.sv
/* Self-checking bench of the retransmission controller.
   Assumes the checker is bound and the node model stands at the MAC port. */
`timescale 1ns/1ps
`default_nettype none
module imm_ack_retransmit_control_tb;
  typedef struct packed {
    logic [5:0] src;
    logic wide, ss, utc, ok;
    logic [1:0] tp;
    logic est, utce;
    logic [5:0] rec, asg;
    logic [36:0] ack;
    logic [7:0] ext;
  } iar_row_s;
  logic mclk_i, nrst_i, frm_req_i, frm_ack_i, frm_mcast_i, frm_ss_i;
  logic [7:0] frm_id_i, frm_nmpdu_i, frm_id_o, mpdu_idx_o, rext_i, text_o;
  logic frm_ready_o, frm_done_o, frm_fail_o, p3_req_i, p3_rx_busy_i;
  logic mpdu_send_o, mpdu_ackreq_o, mpdu_ss_o, mpdu_p3_o, mpdu_abort_o;
  logic mpdu_done_i, rack_valid_i, tack_build_i, tack_wide_i, tack_ss_i;
  logic tack_utc_i, tack_ok_i, tack_est_ok_i, tack_utce_i, res;
  logic [36:0] rack_i, tack_o;
  logic [1:0] tack_tp_req_i, mode;
  logic [5:0] tack_src_i, tack_rec_i, tack_asg_i;
  logic [3:0] lat;
  int mismatches, check_count, cyc, p3_sent, ss_sent, aborts, sends;
  // layouts; narrow request without selective ack
  iar_row_s rows[6] = '{
    '{6'h01, 1'h1, 1'h0, 1'h0, 1'h1, 2'h3, 1'h1, 1'h0, 6'h25, 6'h00, 37'h9c0200000, 8'h00},
    '{6'h02, 1'h0, 1'h0, 1'h0, 1'h0, 2'h3, 1'h1, 1'h1, 6'h1a, 6'h00, 37'h016000000, 8'h02},
    '{6'h03, 1'h1, 1'h1, 1'h0, 1'h1, 2'h3, 1'h1, 1'h0, 6'h3b, 6'h00, 37'h003600000, 8'h01},
    '{6'h04, 1'h1, 1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0, 6'h3f, 6'h29, 37'h8c0100000, 8'h00},
    '{6'h05, 1'h1, 1'h0, 1'h0, 1'h1, 2'h3, 1'h0, 1'h0, 6'h25, 6'h00, 37'h000200000, 8'h00},
    '{6'h05, 1'h1, 1'h0, 1'h0, 1'h1, 2'h0, 1'h1, 1'h0, 6'h25, 6'h00, 37'h9c0200000, 8'h00}};
  iar_retx_ctrl #(.MAX_RETX(3), .MAX_ACK_RX_CYC(150), .ACK_WAIT_CYC(20)) dut (.*);
  iar_node_model u_node (.mclk_i(mclk_i), .nrst_i(nrst_i), .send_i(mpdu_send_o),
    .abort_i(mpdu_abort_o), .mode_i(mode), .lat_i(lat), .done_o(mpdu_done_i),
    .ack_v_o(rack_valid_i), .ack_o(rack_i), .ext_o(rext_i));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    // The priority 3 request is held until its own MPDU completes
    if (mpdu_done_i && p3_sent > 0) p3_req_i <= 1'b0;
    if (rack_valid_i && mode == 2'h2) mode <= 2'h0;
    if (mpdu_send_o && mpdu_p3_o) p3_sent++;
    if (mpdu_send_o && mpdu_ss_o) ss_sent++;
    if (mpdu_abort_o) aborts++;
    if (cyc == 20000) begin
      mismatches++;
      summarize;
    end
  end
  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [7:0] id, input logic [7:0] n, input logic mc);
    int i;
    sends = 0;
    while (frm_ready_o !== 1'b1) tick;
    {frm_id_i, frm_nmpdu_i, frm_ack_i, frm_mcast_i, frm_req_i} = {id, n, 1'b1, mc, 1'b1};
    tick;
    frm_req_i = 1'b0;
    for (i = 0; i < 900 && frm_done_o !== 1'b1 && frm_fail_o !== 1'b1; i++) begin
      if (mpdu_send_o) sends++;
      tick;
    end
    res = frm_done_o;
    check(37'(frm_done_o | frm_fail_o), 37'h1);
    check(37'(frm_id_o), 37'(id));
    $display("frame %h ends, done %b sends %0d", id, res, sends);
    tick;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {frm_req_i, frm_ack_i, frm_mcast_i, frm_ss_i, frm_id_i, frm_nmpdu_i} = '0;
    {p3_req_i, p3_rx_busy_i, tack_build_i, tack_wide_i, tack_ss_i, tack_utc_i} = '0;
    {tack_ok_i, tack_est_ok_i, tack_utce_i, tack_tp_req_i, tack_src_i} = '0;
    {tack_rec_i, tack_asg_i, mode, nrst_i} = '0;
    lat = 4'h2;
    repeat (8) @(posedge mclk_i);
    check(37'(frm_ready_o | mpdu_send_o | frm_fail_o), 37'h0);
    #1 nrst_i = 1'b1;
    tick;
    tick;
    check(37'(frm_ready_o), 37'h1);
    $display("reset test ends");
    foreach (rows[k]) begin
      {tack_src_i, tack_wide_i, tack_ss_i, tack_utc_i, tack_ok_i, tack_tp_req_i} =
        {rows[k].src, rows[k].wide, rows[k].ss, rows[k].utc, rows[k].ok, rows[k].tp};
      {tack_est_ok_i, tack_utce_i, tack_rec_i, tack_asg_i} =
        {rows[k].est, rows[k].utce, rows[k].rec, rows[k].asg};
      tack_build_i = 1'b1;
      tick;
      tack_build_i = 1'b0;
      check(tack_o, rows[k].ack);
      check(37'(text_o), 37'(rows[k].ext));
      $display("ack row %0d ends", k);
      tick;
    end
    frame(8'h11, 8'h02, 1'b0);
    check(37'(sends), 37'h2);
    frame(8'h12, 8'h01, 1'b1);
    check(37'(res), 37'h1);
    mode = 2'h1;
    frame(8'h13, 8'h01, 1'b0);
    check(37'({res, 4'(sends)}), 37'h04);
    mode = 2'h2;
    frame(8'h14, 8'h01, 1'b0);
    check(37'({res, 4'(ss_sent)}), 37'h11);
    lat = 4'hf;
    frame(8'h15, 8'h0a, 1'b0);
    check(37'(res), 37'h0);
    // Window expiry hits while the seventh of the ten MPDUs is still in flight
    check(37'(aborts), 37'h1);
    fork
      frame(8'h16, 8'h07, 1'b0);
      begin
        repeat (10) tick;
        {p3_req_i, p3_rx_busy_i} = 2'h3;
        repeat (80) tick;
        p3_rx_busy_i = 1'b0;
      end
    join
    check(37'({res, 4'(p3_sent), 4'(aborts)}), 37'h112);
    summarize;
  end
endmodule // imm_ack_retransmit_control_tb
`default_nettype wire
